// File: rtl/erc_pkg.sv
// Constants and types shared by the embedded RAM clocking block
package erc_pkg;

  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] CFG_OFF = 12'h000;
  localparam logic [APB_AW-1:0] STAT_OFF = 12'h004;

  localparam int CFG_W = 6;
  localparam int CFG_SCHEME_LSB = 0;
  localparam int CFG_CONF_LSB = 2;
  localparam int CFG_OREG_LSB = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h03;

  localparam int STAT_BAD_BIT = 0;
  localparam int STAT_UNK_LSB = 1;
  localparam int STAT_WCON_BIT = 3;
  localparam int STAT_W = 4;

  localparam int PORT_A = 0;
  localparam int PORT_B = 1;

  typedef enum logic [1:0] {ERC_INDEP, ERC_INOUT, ERC_RDWR, ERC_SINGLE} erc_scheme_type;
  typedef enum logic [1:0] {ERC_TDP, ERC_SDP, ERC_SP, ERC_CONF_BAD} erc_conf_type;

endpackage

// File: rtl/erc_sync.sv
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/100ps
`default_nettype none
module erc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule
`default_nettype wire

// File: rtl/erc_mem.sv
// Two-port storage array with byte enables and registered read data
`timescale 1ns/100ps
`default_nettype none
module erc_mem #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16,
  parameter logic [DATA_W-1:0] INIT_VALUE = '0
) (
  input wire logic pclk,
  input wire logic wr_en_a,
  input wire logic wr_en_b,
  input wire logic [ADDR_W-1:0] wr_addr_a,
  input wire logic [ADDR_W-1:0] wr_addr_b,
  input wire logic [DATA_W-1:0] wr_data_a,
  input wire logic [DATA_W-1:0] wr_data_b,
  input wire logic [DATA_W/8-1:0] wr_be_a,
  input wire logic [DATA_W/8-1:0] wr_be_b,
  input wire logic [ADDR_W-1:0] rd_addr_a,
  input wire logic [ADDR_W-1:0] rd_addr_b,
  output logic [DATA_W-1:0] rd_data_a,
  output logic [DATA_W-1:0] rd_data_b
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int BE_W = DATA_W / 8;

  logic [DATA_W-1:0] mem [DEPTH];

  // preload content
  // Preloaded content stands in for an initialisation file
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = INIT_VALUE;
    end
  end

  // no async clear
  // Port B is written last, so it wins a same-address collision
  always_ff @(posedge pclk) begin
    for (int k = 0; k < BE_W; k++) begin
      if (wr_en_a && wr_be_a[k]) begin
        mem[wr_addr_a][k*8 +: 8] <= wr_data_a[k*8 +: 8];
      end
      if (wr_en_b && wr_be_b[k]) begin
        mem[wr_addr_b][k*8 +: 8] <= wr_data_b[k*8 +: 8];
      end
    end
    rd_data_a <= mem[rd_addr_a];
    rd_data_b <= mem[rd_addr_b];
  end

endmodule
`default_nettype wire

// File: rtl/erc_ram_top.sv
// Embedded RAM with selectable clock schemes, read-during-write and APB config
`timescale 1ns/100ps
`default_nettype none
module erc_ram_top import erc_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16,
  parameter logic [DATA_W-1:0] INIT_VALUE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clk_a,
  input wire logic clk_b,
  input wire logic ce_in_a,
  input wire logic ce_in_b,
  input wire logic ce_out_a,
  input wire logic ce_out_b,
  input wire logic we_a,
  input wire logic we_b,
  input wire logic re_a,
  input wire logic re_b,
  input wire logic [ADDR_W-1:0] addr_a,
  input wire logic [ADDR_W-1:0] addr_b,
  input wire logic [DATA_W-1:0] din_a,
  input wire logic [DATA_W-1:0] din_b,
  input wire logic [DATA_W/8-1:0] be_a,
  input wire logic [DATA_W/8-1:0] be_b,
  output logic [DATA_W-1:0] dout_a,
  output logic [DATA_W-1:0] dout_b
);

  localparam int BE_W = DATA_W / 8;
  localparam int SW = 10 + 2 * (ADDR_W + DATA_W + BE_W);

  if (DATA_W % 8 != 0 || DATA_W < 8 || DATA_W > 32 || ADDR_W < 1 || ADDR_W > 16) begin : g_bad
    $error("erc_ram_top: unsupported ADDR_W or DATA_W");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection

  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_syn;
  logic [1:0] clk_s, ce_in_s, ce_out_s, we_s, re_s;
  logic [ADDR_W-1:0] addr_s [2];
  logic [DATA_W-1:0] din_s [2];
  logic [BE_W-1:0] be_s [2];

  // All pins share one synchroniser so data stays aligned with its clock
  assign pins_raw = {be_b, be_a, din_b, din_a, addr_b, addr_a, re_b, re_a,
                     we_b, we_a, ce_out_b, ce_out_a, ce_in_b, ce_in_a, clk_b, clk_a};

  erc_sync #(.WIDTH(SW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pins_raw),
    .dout(pins_syn)
  );

  assign {be_s[1], be_s[0], din_s[1], din_s[0], addr_s[1], addr_s[0], re_s,
          we_s, ce_out_s, ce_in_s, clk_s} = pins_syn;

  logic [1:0] clk_d_reg, clk_d_next, rise, fall;
  logic rst_meta_reg, rst_sync_reg, srst;

  always_comb begin
    clk_d_next = clk_s;
    rise = clk_s & ~clk_d_reg;
    fall = ~clk_s & clk_d_reg;
  end

  // synchronous reset only
  // Datapath registers clear through a synchronised reset, never asynchronously
  always_ff @(posedge pclk) begin
    clk_d_reg <= clk_d_next;
    rst_meta_reg <= presetn;
    rst_sync_reg <= rst_meta_reg;
  end

  assign srst = !rst_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode

  logic [CFG_W-1:0] cfg_reg, cfg_next;
  erc_scheme_type scheme;
  erc_conf_type conf;
  logic cfg_bad;
  logic [1:0] oreg_en, wr_ok, rd_ok;

  assign scheme = erc_scheme_type'(cfg_reg[CFG_SCHEME_LSB +: 2]);
  assign conf = erc_conf_type'(cfg_reg[CFG_CONF_LSB +: 2]);
  assign oreg_en = cfg_reg[CFG_OREG_LSB +: 2];

  // scheme legality
  // An illegal pairing stops captures and new writes; a write already pending still commits
  assign cfg_bad = (conf == ERC_CONF_BAD) ||
                   (scheme == ERC_INDEP && conf != ERC_TDP) ||
                   (scheme == ERC_RDWR && conf != ERC_SDP);

  // Simple dual-port writes only on A and reads only on B; single-port has no B
  assign wr_ok[PORT_A] = 1'b1;
  assign wr_ok[PORT_B] = (conf == ERC_TDP);
  assign rd_ok[PORT_A] = (conf != ERC_SDP);
  assign rd_ok[PORT_B] = (conf != ERC_SP);

  // Which synchronised clock feeds a port's input or output registers
  function automatic logic clk_src(erc_scheme_type sch, int p, logic out_side);
    unique case (sch)
      ERC_INDEP: clk_src = p[0];
      ERC_INOUT: clk_src = out_side;
      ERC_RDWR: clk_src = p[0];
      ERC_SINGLE: clk_src = 1'b0;
    endcase
  endfunction

  // Which clock enable qualifies a port's input or output registers
  function automatic logic ce_src(erc_scheme_type sch, int p, logic out_side,
                                  logic [1:0] cei, logic [1:0] ceo);
    unique case (sch)
      ERC_INDEP: ce_src = cei[p];
      ERC_INOUT: ce_src = out_side ? ceo[p] : cei[p];
      ERC_RDWR: ce_src = cei[p];
      ERC_SINGLE: ce_src = cei[PORT_A];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Port datapaths

  logic [1:0] in_clk, out_clk, in_rise, in_fall, out_rise, in_ce, out_ce;
  logic [1:0] cap, mem_wr;
  logic [1:0] pend_reg, unk_set;
  logic [ADDR_W-1:0] addr_reg [2];
  logic [DATA_W-1:0] din_reg [2];
  logic [BE_W-1:0] be_reg [2];
  logic [DATA_W-1:0] rd_data [2];
  logic [DATA_W-1:0] dout_reg [2];
  logic wcon_set;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      in_clk[p] = clk_src(scheme, p, 1'b0);
      out_clk[p] = clk_src(scheme, p, 1'b1);
      in_ce[p] = ce_src(scheme, p, 1'b0, ce_in_s, ce_out_s);
      out_ce[p] = ce_src(scheme, p, 1'b1, ce_in_s, ce_out_s);
      in_rise[p] = rise[in_clk[p]];
      in_fall[p] = fall[in_clk[p]];
      out_rise[p] = rise[out_clk[p]];
      cap[p] = in_rise[p] && in_ce[p] && !cfg_bad;
      mem_wr[p] = in_fall[p] && pend_reg[p];
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int Q = 1 - p;
    logic [ADDR_W-1:0] addr_next;
    logic [DATA_W-1:0] din_next, qu_reg, qu_next, oq_reg, oq_next, dout_next;
    logic [BE_W-1:0] be_next;
    logic pend_next, rdp_reg, rdp_next, byp_reg, byp_next;
    logic do_wr, do_rd;

    always_comb begin
      do_wr = we_s[p] && wr_ok[p];
      do_rd = re_s[p] && rd_ok[p];
      addr_next = addr_reg[p];
      din_next = din_reg[p];
      be_next = be_reg[p];
      pend_next = pend_reg[p] && !mem_wr[p];
      rdp_next = 1'b0;
      byp_next = byp_reg;
      qu_next = qu_reg;
      oq_next = oq_reg;
      unk_set[p] = 1'b0;
      if (cap[p]) begin
        addr_next = addr_s[p];
        din_next = din_s[p];
        be_next = be_s[p];
        pend_next = do_wr;
        rdp_next = do_rd;
        byp_next = do_wr && do_rd;
        unk_set[p] = do_rd && (in_clk[p] != in_clk[Q]) &&
                     ((pend_reg[Q] && addr_s[p] == addr_reg[Q]) ||
                      (cap[Q] && we_s[Q] && wr_ok[Q] && addr_s[p] == addr_s[Q]));
      end
      // old data mixed-port
      // The array read precedes any commit, which needs a later falling edge
      if (rdp_reg) begin
        qu_next = rd_data[p];
        for (int k = 0; k < BE_W; k++) begin
          if (byp_reg && be_reg[p][k]) begin
            qu_next[k*8 +: 8] = din_reg[p][k*8 +: 8];
          end
        end
      end
      if (out_rise[p] && out_ce[p] && !cfg_bad) begin
        oq_next = qu_reg;
      end
      dout_next = oreg_en[p] ? oq_reg : qu_reg;
    end

    always_ff @(posedge pclk) begin
      if (srst) begin
        pend_reg[p] <= 1'b0;
        rdp_reg <= 1'b0;
        byp_reg <= 1'b0;
        qu_reg <= '0;
        oq_reg <= '0;
        dout_reg[p] <= '0;
        addr_reg[p] <= '0;
        din_reg[p] <= '0;
        be_reg[p] <= '0;
      end else begin
        pend_reg[p] <= pend_next;
        rdp_reg <= rdp_next;
        byp_reg <= byp_next;
        qu_reg <= qu_next;
        oq_reg <= oq_next;
        dout_reg[p] <= dout_next;
        addr_reg[p] <= addr_next;
        din_reg[p] <= din_next;
        be_reg[p] <= be_next;
      end
    end
  end

  assign wcon_set = mem_wr[PORT_A] && mem_wr[PORT_B] && addr_reg[PORT_A] == addr_reg[PORT_B];
  assign dout_a = dout_reg[PORT_A];
  assign dout_b = dout_reg[PORT_B];

  erc_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .INIT_VALUE(INIT_VALUE)) u_mem (
    .pclk(pclk),
    .wr_en_a(mem_wr[PORT_A]),
    .wr_en_b(mem_wr[PORT_B]),
    .wr_addr_a(addr_reg[PORT_A]),
    .wr_addr_b(addr_reg[PORT_B]),
    .wr_data_a(din_reg[PORT_A]),
    .wr_data_b(din_reg[PORT_B]),
    .wr_be_a(be_reg[PORT_A]),
    .wr_be_b(be_reg[PORT_B]),
    .rd_addr_a(addr_s[PORT_A]),
    .rd_addr_b(addr_s[PORT_B]),
    .rd_data_a(rd_data[PORT_A]),
    .rd_data_b(rd_data[PORT_B])
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, registered answer

  logic [STAT_W-1:0] stat_val;
  logic [1:0] unk_reg, unk_next;
  logic wcon_reg, wcon_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic access, done, hit_cfg, hit_stat;

  assign stat_val = {wcon_reg, unk_reg, cfg_bad};

  always_comb begin
    access = psel && penable && !pready_reg;
    done = psel && penable && pready_reg;
    hit_cfg = (paddr == CFG_OFF);
    hit_stat = (paddr == STAT_OFF);
    pready_next = access;
    pslverr_next = access && !hit_cfg && !hit_stat;
    prdata_next = '0;
    if (access && !pwrite && hit_cfg) begin
      prdata_next[CFG_W-1:0] = cfg_reg;
    end else if (access && !pwrite && hit_stat) begin
      prdata_next[STAT_W-1:0] = stat_val;
    end
    cfg_next = cfg_reg;
    unk_next = unk_reg;
    wcon_next = wcon_reg;
    if (done && pwrite && pstrb[0]) begin
      if (hit_cfg) begin
        cfg_next = pwdata[CFG_W-1:0];
      end
      if (hit_stat) begin
        unk_next = unk_reg & ~pwdata[STAT_UNK_LSB +: 2];
        wcon_next = wcon_reg && !pwdata[STAT_WCON_BIT];
      end
    end
    // A new event in the clearing cycle survives the clear
    unk_next = unk_next | unk_set;
    wcon_next = wcon_next || wcon_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= CFG_RESET;
      unk_reg <= '0;
      wcon_reg <= 1'b0;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      unk_reg <= unk_next;
      wcon_reg <= wcon_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule
`default_nettype wire

// File: tb/erc_ram_props.sv
// Assertion checker bound to the ports of the embedded RAM top
`timescale 1ns/100ps
`default_nettype none
module erc_ram_props import erc_pkg::*; #(
  parameter int DATA_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic clk_a,
  input wire logic clk_b,
  input wire logic ce_in_a,
  input wire logic ce_in_b,
  input wire logic ce_out_a,
  input wire logic ce_out_b,
  input wire logic [DATA_W-1:0] dout_a,
  input wire logic [DATA_W-1:0] dout_b
);
  logic [3:0] clk_idle_reg;
  logic [3:0] clk_idle_next;
  logic [3:0] ce_idle_reg;
  logic [3:0] ce_idle_next;
  logic req_first;
  logic mapped;
  ////////////////////////////////////////////////////////////////////////////////
  // Idle counts saturate so a long quiet spell never wraps into a false pass
  always_comb begin
    clk_idle_next = (clk_idle_reg == 4'hF) ? 4'hF : clk_idle_reg + 4'h1;
    ce_idle_next = (ce_idle_reg == 4'hF) ? 4'hF : ce_idle_reg + 4'h1;
    if (clk_a || clk_b) begin
      clk_idle_next = 4'h0;
    end
    if (ce_in_a || ce_in_b || ce_out_a || ce_out_b) begin
      ce_idle_next = 4'h0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_idle_reg <= 4'h0;
      ce_idle_reg <= 4'h0;
    end else begin
      clk_idle_reg <= clk_idle_next;
      ce_idle_reg <= ce_idle_next;
    end
  end
  assign req_first = psel && penable && !pready;
  assign mapped = (paddr == CFG_OFF) || (paddr == STAT_OFF);
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  answer_wait_a: assert property (req_first |=> pready)
    else $error("no answer one cycle after access");
  unmapped_err_a: assert property (req_first && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (req_first && mapped |=> !pslverr)
    else $error("mapped access refused");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read bus active outside answer");
  // A config write may switch the output mux, so it moves dout two cycles on
  dout_clk_a: assert property ($changed(dout_a) && !$past(pready, 2) |-> clk_idle_reg < 4'h8)
    else $error("dout_a moved without a port clock");
  dout_b_clk_a: assert property ($changed(dout_b) && !$past(pready, 2) |-> clk_idle_reg < 4'h8)
    else $error("dout_b moved without a port clock");
  dout_ce_a: assert property ($changed(dout_a) || $changed(dout_b) |-> ce_idle_reg < 4'h8)
    else $error("output moved with all enables low");
  power_zero_a: assert property ($rose(presetn) |-> dout_a == '0 && dout_b == '0)
    else $error("outputs not zero after reset");
  cover property (pslverr);
  cover property (psel && penable && pwrite && paddr == CFG_OFF);
  cover property ($changed(dout_b));
endmodule
bind erc_ram_top erc_ram_props #(.DATA_W(DATA_W)) u_props (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .clk_a(clk_a), .clk_b(clk_b), .ce_in_a(ce_in_a),
  .ce_in_b(ce_in_b), .ce_out_a(ce_out_a), .ce_out_b(ce_out_b), .dout_a(dout_a),
  .dout_b(dout_b));
`default_nettype wire

// File: tb/erc_user_model.sv
// Fabric user-logic model driving the RAM port pins with legal hold times
`timescale 1ns/100ps
`default_nettype none
module erc_user_model #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  input wire logic pclk,
  output var logic clk_a,
  output var logic clk_b,
  output var logic ce_in_a,
  output var logic ce_in_b,
  output var logic ce_out_a,
  output var logic ce_out_b,
  output var logic we_a,
  output var logic we_b,
  output var logic re_a,
  output var logic re_b,
  output var logic [ADDR_W-1:0] addr_a,
  output var logic [ADDR_W-1:0] addr_b,
  output var logic [DATA_W-1:0] din_a,
  output var logic [DATA_W-1:0] din_b,
  output var logic [DATA_W/8-1:0] be_a,
  output var logic [DATA_W/8-1:0] be_b
);
  initial begin
    {clk_a, clk_b, we_a, we_b, re_a, re_b} = 6'h00;
    {ce_in_a, ce_in_b, ce_out_a, ce_out_b} = 4'hF;
    {addr_a, addr_b, din_a, din_b, be_a, be_b} = '0;
  end
  task automatic set_a(input logic w, input logic r, input logic [ADDR_W-1:0] ad,
      input logic [DATA_W-1:0] d, input logic [DATA_W/8-1:0] b);
    @(posedge pclk);
    {we_a, re_a, addr_a, din_a, be_a} <= {w, r, ad, d, b};
  endtask
  task automatic set_b(input logic w, input logic r, input logic [ADDR_W-1:0] ad,
      input logic [DATA_W-1:0] d, input logic [DATA_W/8-1:0] b);
    @(posedge pclk);
    {we_b, re_b, addr_b, din_b, be_b} <= {w, r, ad, d, b};
  endtask
  task automatic set_ce(input logic [3:0] v);
    @(posedge pclk);
    {ce_in_a, ce_in_b, ce_out_a, ce_out_b} <= v;
  endtask
  // Clocks stand still between pulses; pins stay put well past the sync window
  task automatic pulse(input logic [1:0] m);
    repeat (3) @(posedge pclk);
    {clk_b, clk_a} <= m;
    repeat (4) @(posedge pclk);
    {clk_b, clk_a} <= 2'b00;
    repeat (4) @(posedge pclk);
    // released lines carry garbage, nothing downstream trusts them
    {we_a, we_b, re_a, re_b} <= 4'h0;
    {addr_a, addr_b, din_a, din_b} <= ~{addr_a, addr_b, din_a, din_b};
    repeat (6) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the embedded RAM top over APB and the port pins
`timescale 1ns/100ps
`default_nettype none
module tb import erc_pkg::*; ;
  localparam logic [15:0] IV = 16'hA5C3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic clk_a, clk_b, ce_in_a, ce_in_b, ce_out_a, ce_out_b, we_a, we_b, re_a, re_b;
  logic [7:0] addr_a, addr_b;
  logic [15:0] din_a, din_b, dout_a, dout_b;
  logic [1:0] be_a, be_b;
  int mismatches;
  int n_compared;
  erc_ram_top #(.ADDR_W(8), .DATA_W(16), .INIT_VALUE(IV)) dut (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_a(clk_a), .clk_b(clk_b), .ce_in_a(ce_in_a), .ce_in_b(ce_in_b), .ce_out_a(ce_out_a),
    .ce_out_b(ce_out_b), .we_a(we_a), .we_b(we_b), .re_a(re_a), .re_b(re_b),
    .addr_a(addr_a), .addr_b(addr_b), .din_a(din_a), .din_b(din_b), .be_a(be_a),
    .be_b(be_b), .dout_a(dout_a), .dout_b(dout_b));
  erc_user_model #(.ADDR_W(8), .DATA_W(16)) u (.pclk(pclk), .clk_a(clk_a), .clk_b(clk_b),
    .ce_in_a(ce_in_a), .ce_in_b(ce_in_b), .ce_out_a(ce_out_a), .ce_out_b(ce_out_b),
    .we_a(we_a), .we_b(we_b), .re_a(re_a), .re_b(re_b), .addr_a(addr_a), .addr_b(addr_b),
    .din_a(din_a), .din_b(din_b), .be_a(be_a), .be_b(be_b));
  always #50 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chd(input string n, input logic [15:0] e, input logic [15:0] g);
    chk(n, {16'h0, e}, {16'h0, g});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    last_err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic cfg(input logic [5:0] v);
    apb(1'b1, CFG_OFF, {26'h0, v});
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic ra(input logic [7:0] ad, input logic [1:0] m);
    u.set_a(1'b0, 1'b1, ad, 16'h0, 2'h0);
    u.pulse(m);
  endtask
  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chd("dout_a", 16'h0, dout_a);
    chd("dout_b", 16'h0, dout_b);
    rdc("cfg", CFG_OFF, 32'h3);
    rdc("stat", STAT_OFF, 32'h0);
    rdc("unmapped", 12'h008, 32'h0);
    chk("slverr", 32'h1, {31'h0, last_err});
    // A write without its low byte strobe leaves the config alone
    pstrb <= 4'h0;
    cfg(6'h00);
    pstrb <= 4'hF;
    rdc("strb_off", CFG_OFF, 32'h3);
    ra(8'h05, 2'b01);
    chd("preload", IV, dout_a);
    u.set_a(1'b1, 1'b1, 8'h07, 16'h1234, 2'h3);
    u.pulse(2'b01);
    chd("rdw_new", 16'h1234, dout_a);
    u.set_a(1'b1, 1'b1, 8'h07, 16'h56AB, 2'h1);
    u.pulse(2'b01);
    chd("rdw_byte", 16'h00AB, {8'h0, dout_a[7:0]});
    u.set_a(1'b1, 1'b0, 8'h09, 16'hBEEF, 2'h3);
    u.set_b(1'b0, 1'b1, 8'h09, 16'h0, 2'h0);
    u.pulse(2'b01);
    chd("mixed_old", IV, dout_b);
    u.set_b(1'b0, 1'b1, 8'h09, 16'h0, 2'h0);
    u.pulse(2'b01);
    chd("mixed_new", 16'hBEEF, dout_b);
    cfg(6'h00);
    u.set_a(1'b1, 1'b0, 8'h14, 16'hC0DE, 2'h3);
    u.pulse(2'b01);
    u.set_b(1'b0, 1'b1, 8'h14, 16'h0, 2'h0);
    u.pulse(2'b10);
    chd("indep_b", 16'hC0DE, dout_b);
    ra(8'h14, 2'b01);
    u.set_ce(4'b0111);
    u.set_a(1'b0, 1'b1, 8'h05, 16'h0, 2'h0);
    u.set_b(1'b0, 1'b1, 8'h09, 16'h0, 2'h0);
    u.pulse(2'b11);
    chd("stall_a", 16'hC0DE, dout_a);
    chd("run_b", 16'hBEEF, dout_b);
    u.set_ce(4'hF);
    // different clocks: only the flag is judged
    u.set_a(1'b1, 1'b0, 8'h1E, 16'h7777, 2'h3);
    u.set_b(1'b0, 1'b1, 8'h1E, 16'h0, 2'h0);
    u.pulse(2'b11);
    apb(1'b0, STAT_OFF, 32'h0);
    chk("unk_b", 32'h4, rd & 32'h4);
    // Both ports commit the same word on one falling edge: contention flagged
    u.set_a(1'b1, 1'b0, 8'h2A, 16'h1111, 2'h3);
    u.set_b(1'b1, 1'b0, 8'h2A, 16'h2222, 2'h3);
    u.pulse(2'b11);
    apb(1'b0, STAT_OFF, 32'h0);
    chk("wcon", 32'h8, rd & 32'h8);
    apb(1'b1, STAT_OFF, 32'hE);
    rdc("stat_clr", STAT_OFF, 32'h0);
    cfg(6'h06);
    u.set_a(1'b1, 1'b0, 8'h20, 16'h1357, 2'h3);
    u.pulse(2'b01);
    u.set_ce(4'b0111);
    u.set_a(1'b1, 1'b0, 8'h20, 16'hFFFF, 2'h3);
    u.pulse(2'b01);
    u.set_ce(4'hF);
    u.set_b(1'b0, 1'b1, 8'h20, 16'h0, 2'h0);
    u.pulse(2'b10);
    chd("rdwr_b", 16'h1357, dout_b);
    cfg(6'h31);
    ra(8'h14, 2'b01);
    u.pulse(2'b10);
    chd("io_first", 16'hC0DE, dout_a);
    ra(8'h20, 2'b01);
    chd("io_wait", 16'hC0DE, dout_a);
    u.set_ce(4'b1101);
    u.pulse(2'b10);
    chd("io_hold", 16'hC0DE, dout_a);
    u.set_ce(4'hF);
    u.pulse(2'b10);
    chd("io_out", 16'h1357, dout_a);
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 4; c++) begin
        cfg({2'b00, c[1:0], s[1:0]});
        apb(1'b0, STAT_OFF, 32'h0);
        chk("cfg_bad", {31'h0, c == 3 || (s == 0 && c != 0) || (s == 2 && c != 1)},
          rd & 32'h1);
      end
    end
    u.set_a(1'b1, 1'b1, 8'h14, 16'hFFFF, 2'h3);
    u.pulse(2'b01);
    chd("bad_hold", 16'h1357, dout_a);
    // reset again: outputs clear, array kept
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    chd("rst_dout", 16'h0, dout_a);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    ra(8'h14, 2'b01);
    chd("kept", 16'hC0DE, dout_a);
    summarize();
  end
endmodule
`default_nettype wire
